// ==== rtl/itg_pkg.sv ====
// Constants and state encoding for the two-wire indexed register target.
package itg_pkg;
   // =====================================================================
   // Link framing
   // =====================================================================
   localparam logic [7:0] ITG_ADDR_WR = 8'h52; // Address byte, controller writes.
   localparam logic [7:0] ITG_ADDR_RD = 8'h53; // Address byte, controller reads.
   localparam logic [3:0] ITG_BYTE_BITS = 4'h8; // Data bits before the acknowledge slot.
   localparam logic [15:0] ITG_PTR_RST = 16'h0000; // Register pointer after reset.
   localparam logic [15:0] ITG_PTR_STEP = 16'h0001; // Pointer advance per byte.

   // =====================================================================
   // Timing
   // =====================================================================
   localparam int ITG_SYS_CLK_NS = 100; // Period of clk_sys.
   localparam int ITG_SPIKE_NS = 50; // Widest pulse the input filter must swallow.
   localparam int ITG_SPIKE_CYC = (ITG_SPIKE_NS + ITG_SYS_CLK_NS - 1) / ITG_SYS_CLK_NS;
   localparam int ITG_MAX_KBPS = 1000; // Fastest link bit rate.
   localparam int ITG_SCL_LOW_NS = 500; // Least clock low time at the fastest rate.
   localparam int ITG_SCL_LOW_CYC = ITG_SCL_LOW_NS / ITG_SYS_CLK_NS;

   // =====================================================================
   // Input lanes of the synchroniser
   // =====================================================================
   localparam int ITG_LANES = 3;
   localparam int ITG_LANE_SCL = 0;
   localparam int ITG_LANE_SDA = 1;
   localparam int ITG_LANE_RST = 2;

   // Message phase, Gray coded along address, index high, index low, write.
   typedef enum logic [2:0] {
      ITG_ST_IDLE = 3'h0,
      ITG_ST_ADDR = 3'h1,
      ITG_ST_IDXH = 3'h3,
      ITG_ST_IDXL = 3'h2,
      ITG_ST_WR = 3'h6,
      ITG_ST_RD = 3'h7
   } itg_state_t;
endpackage : itg_pkg

// ==== rtl/itg_target.sv ====
// Two-wire serial target port with a 16-bit auto-incrementing register pointer.
`timescale 1ns/1ps
module itg_target
   import itg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic iface_rst,
   output logic [15:0] reg_ptr,
   input wire logic [7:0] reg_rdata,
   output logic [15:0] reg_waddr,
   output logic [7:0] reg_wdata,
   output logic reg_we
);

   // =====================================================================
   // Input synchronisers and glitch filter
   // =====================================================================
   logic [ITG_LANES-1:0] s1_q;
   logic [ITG_LANES-1:0] s2_q;
   logic [ITG_LANES-1:0] s3_q;
   logic [ITG_LANES-1:0] flt_q;
   logic [ITG_LANES-1:0] flt_d;

   // sync then filter
   // A lane only changes once taps two and three agree, so a pulse shorter than
   // one clock period (ITG_SPIKE_CYC) never reaches the edge detectors.
   genvar gi;
   generate
      for (gi = 0; gi < ITG_LANES; gi++) begin : g_lane
         assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
         // Pads idle high through their pull-ups, except the reset pin.
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               s1_q[gi] <= (gi != ITG_LANE_RST);
               s2_q[gi] <= (gi != ITG_LANE_RST);
               s3_q[gi] <= (gi != ITG_LANE_RST);
               flt_q[gi] <= (gi != ITG_LANE_RST);
            end else begin
               s1_q[gi] <= (gi == ITG_LANE_SCL) ? scl_in : (gi == ITG_LANE_SDA) ? sda_in : iface_rst;
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               flt_q[gi] <= flt_d[gi];
            end
         end
      end
   endgenerate

   // =====================================================================
   // Edge and framing detection
   // =====================================================================
   // sampling margin
   // At 1 Mbit/s the clock stays low ITG_SCL_LOW_CYC system cycles, enough for
   // the three-tap path; slower rates down to a stopped clock simply wait.
   wire scl_f = flt_d[ITG_LANE_SCL];
   wire sda_f = flt_d[ITG_LANE_SDA];
   wire rst_f = flt_d[ITG_LANE_RST];
   wire scl_rise = scl_f & ~flt_q[ITG_LANE_SCL];
   wire scl_fall = ~scl_f & flt_q[ITG_LANE_SCL];
   wire start_det = scl_f & flt_q[ITG_LANE_SCL] & ~sda_f & flt_q[ITG_LANE_SDA];
   wire stop_det = scl_f & flt_q[ITG_LANE_SCL] & sda_f & ~flt_q[ITG_LANE_SDA];

   // =====================================================================
   // Message state
   // =====================================================================
   itg_state_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic ack_q, ack_d;
   logic [7:0] sh_q, sh_d;
   logic oe_q, oe_d;
   logic [15:0] ptr_q, ptr_d;
   logic [15:0] wa_q, wa_d;
   logic [7:0] wd_q, wd_d;
   logic we_q, we_d;
   logic zero_q;

   wire byte_done = (bit_q == ITG_BYTE_BITS);
   wire addr_hit = (sh_q[7:1] == ITG_ADDR_WR[7:1]);

   // Next-state logic. Framing events outrank clock edges, and the interface
   // reset outranks everything, so a stuck transfer can always be abandoned.
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      ack_d = ack_q;
      sh_d = sh_q;
      oe_d = oe_q;
      ptr_d = ptr_q;
      wa_d = wa_q;
      wd_d = wd_q;
      we_d = 1'b0;
      if (rst_f) begin
         st_d = ITG_ST_IDLE;
         bit_d = 4'h0;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = ITG_ST_IDLE;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else if (start_det) begin
         st_d = ITG_ST_ADDR;
         bit_d = 4'h0;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else if (st_q != ITG_ST_IDLE) begin
         if (scl_rise) begin
            if (ack_q) begin
               if (st_q == ITG_ST_RD && sda_f) begin
                  st_d = ITG_ST_IDLE;
                  oe_d = 1'b0;
               end
            end else if (!byte_done) begin
               bit_d = 4'(bit_q + 4'h1);
               if (st_q != ITG_ST_RD) begin
                  sh_d = {sh_q[6:0], sda_f};
               end
            end
         end else if (scl_fall) begin
            if (ack_q) begin
               ack_d = 1'b0;
               bit_d = 4'h0;
               oe_d = 1'b0;
               if (st_q == ITG_ST_RD) begin
                  sh_d = {reg_rdata[6:0], 1'b0};
                  oe_d = ~reg_rdata[7];
               end
            end else if (byte_done) begin
               ack_d = 1'b1;
               oe_d = 1'b1;
               unique case (st_q)
                  ITG_ST_ADDR: begin
                     if (addr_hit) begin
                        st_d = sh_q[0] ? ITG_ST_RD : ITG_ST_IDXH;
                     end else begin
                        st_d = ITG_ST_IDLE;
                        ack_d = 1'b0;
                        oe_d = 1'b0;
                     end
                  end
                  ITG_ST_IDXH: begin
                     ptr_d[15:8] = sh_q;
                     st_d = ITG_ST_IDXL;
                  end
                  ITG_ST_IDXL: begin
                     ptr_d[7:0] = sh_q;
                     st_d = ITG_ST_WR;
                  end
                  ITG_ST_WR: begin
                     we_d = 1'b1;
                     wa_d = ptr_q;
                     wd_d = sh_q;
                     ptr_d = 16'(ptr_q + ITG_PTR_STEP);
                  end
                  ITG_ST_RD: begin
                     oe_d = 1'b0;
                     ptr_d = 16'(ptr_q + ITG_PTR_STEP);
                  end
                  ITG_ST_IDLE: begin
                     oe_d = 1'b0;
                  end
               endcase
            end else if (st_q == ITG_ST_RD && bit_q != 4'h0) begin
               oe_d = ~sh_q[7];
               sh_d = {sh_q[6:0], 1'b0};
            end
         end
      end
   end

   // Message registers. The pointer lives on across interface reset because it
   // belongs to the sensor side; only sys_rst clears it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q <= ITG_ST_IDLE;
         bit_q <= 4'h0;
         ack_q <= 1'b0;
         sh_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         ack_q <= ack_d;
         sh_q <= sh_d;
         oe_q <= oe_d;
      end
   end

   // Register-file side outputs.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ptr_q <= ITG_PTR_RST;
         wa_q <= ITG_PTR_RST;
         wd_q <= 8'h00;
         we_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         ptr_q <= ptr_d;
         wa_q <= wa_d;
         wd_q <= wd_d;
         we_q <= we_d;
         zero_q <= 1'b0;
      end
   end

   // clock never driven
   // The data pad output is a constant low; only its enable moves.
   assign sda_out = zero_q;
   assign sda_oe = oe_q;
   assign reg_ptr = ptr_q;
   assign reg_waddr = wa_q;
   assign reg_wdata = wd_q;
   assign reg_we = we_q;

   // =====================================================================
   // Assertions
   // =====================================================================
   a_ack_on_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!rst_f && !start_det && !stop_det && scl_fall && !ack_q && byte_done && st_q == ITG_ST_ADDR && addr_hit)
      |=> (sda_oe && ack_q && (st_q == ITG_ST_RD || st_q == ITG_ST_IDXH)))
      else $error("matching address not acknowledged");
   a_no_ack_miss: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!rst_f && !start_det && !stop_det && scl_fall && !ack_q && byte_done && st_q == ITG_ST_ADDR && !addr_hit)
      |=> (!sda_oe && st_q == ITG_ST_IDLE))
      else $error("foreign address was acknowledged");
   a_dir_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (st_q == ITG_ST_RD && !rst_f && !start_det && !stop_det) |=> (st_q == ITG_ST_RD || st_q == ITG_ST_IDLE))
      else $error("read message changed direction");
   a_write_incr: assert property (@(posedge clk_sys) disable iff (sys_rst)
      reg_we |-> (reg_ptr == 16'(reg_waddr + ITG_PTR_STEP) && reg_wdata == $past(sh_q)))
      else $error("write did not advance pointer");
   a_we_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
      reg_we |=> !reg_we)
      else $error("write strobe longer than one cycle");
   a_nack_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!rst_f && !start_det && !stop_det && scl_rise && ack_q && st_q == ITG_ST_RD && sda_f)
      |=> (!sda_oe && st_q == ITG_ST_IDLE) [*2])
      else $error("data still driven after read not-acknowledge");
   a_start_frame: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (start_det && !rst_f) |=> (st_q == ITG_ST_ADDR && bit_q == 4'h0 && !sda_oe))
      else $error("start did not open address phase");
   a_stop_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stop_det |=> (st_q == ITG_ST_IDLE && !sda_oe))
      else $error("stop did not return port to idle");
   a_port_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
      rst_f |=> (st_q == ITG_ST_IDLE && !sda_oe && reg_ptr == $past(reg_ptr)))
      else $error("interface reset misbehaved");
   a_sample_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!rst_f && !start_det && !stop_det && scl_rise && !ack_q && !byte_done
       && st_q != ITG_ST_IDLE && st_q != ITG_ST_RD)
      |=> (sh_q[0] == $past(sda_f) && bit_q == 4'($past(bit_q) + 4'h1)))
      else $error("data bit not captured on rising clock");
   a_oe_clk_low: assert property (@(posedge clk_sys) disable iff (sys_rst || rst_f)
      (sda_oe != $past(sda_oe) && $past(sda_oe)) || (sda_oe && !$past(sda_oe)) |-> !$past(scl_f) || !sda_oe)
      else $error("data drive asserted while clock high");
endmodule : itg_target

// ==== dv/itg_host_model.sv ====
// Behavioural two-wire bus controller that drives the target's link pins.
`timescale 1ns/1ps
module itg_host_model (
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   logic glitch = 1'b0;
   logic [7:0] rd_byte;
   event rd_ev;

   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // =====================================================================
   // Bit level
   // =====================================================================
   // clocked write bit
   task automatic send_bit(input logic b);
      #250 sda_low <= !b;
      if (glitch) begin
         // narrow clock and data spikes
         // A clock spike in the low phase and a data spike in the high phase keep both
         // phases whole, so only the filter stands between a spike and a false edge.
         #50 scl_low <= 1'b0;
         #50 scl_low <= 1'b1;
         #150 scl_low <= 1'b0;
         #100 sda_low <= b;
         #50 sda_low <= !b;
         #150 scl_low <= 1'b1;
      end else begin
         #250 scl_low <= 1'b0;
         #300 scl_low <= 1'b1;
      end
   endtask : send_bit

   // sampled bit
   // The long low phase lets target data settle well before the clock rises.
   task automatic recv_bit(output logic b);
      sda_low <= 1'b0;
      #700 scl_low <= 1'b0;
      #150 b = sda_line;
      #150 scl_low <= 1'b1;
      #300;
   endtask : recv_bit

   // =====================================================================
   // Byte and framing level
   // =====================================================================
   // MSB first, acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      recv_bit(ack);
   endtask : send_byte

   task automatic recv_byte(input logic last);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         recv_bit(b);
         rd_byte[i] = b;
      end
      ->rd_ev;
      send_bit(last);
   endtask : recv_byte

   // start or repeat
   // The odd delay keeps the link out of phase with the system clock.
   task automatic start_cond();
      sda_low <= 1'b0;
      #537 scl_low <= 1'b0;
      #300 sda_low <= 1'b1;
      #300 scl_low <= 1'b1;
   endtask : start_cond

   task automatic stop_cond();
      #250 sda_low <= 1'b1;
      #250 scl_low <= 1'b0;
      #300 sda_low <= 1'b0;
      #600;
   endtask : stop_cond
endmodule : itg_host_model

// ==== dv/testbench.sv ====
// Self-checking bench for the two-wire indexed register target.
`timescale 1ns/1ps
module testbench
   import itg_pkg::*;
;
   logic clk_sys;
   logic sys_rst;
   logic iface_rst;
   logic sda_out;
   logic sda_oe;
   logic scl_low;
   logic sda_low;
   logic [15:0] reg_ptr;
   logic [15:0] reg_waddr;
   logic [7:0] reg_wdata;
   logic reg_we;
   logic [7:0] mem [256];
   logic [23:0] wq [$];
   logic [7:0] rq [$];
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   wire logic scl_line = !scl_low;
   wire logic sda_line = !sda_low && !(sda_oe && !sda_out);
   wire logic [7:0] reg_rdata = mem[reg_ptr[7:0]];

   itg_target DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .iface_rst(iface_rst), .reg_ptr(reg_ptr),
      .reg_rdata(reg_rdata), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .reg_we(reg_we));
   itg_host_model u_host (.sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));

   // =====================================================================
   // Clock, timeout and result monitors
   // =====================================================================
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Cuts a hang short; the full run needs well under a quarter of this.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // Register file beside the port; every write must match the oldest note.
   always @(posedge clk_sys) begin
      if (reg_we === 1'b1) begin
         mem[reg_waddr[7:0]] <= reg_wdata;
         check({reg_waddr, reg_wdata}, (wq.size() != 0) ? wq.pop_front() : 24'hxxxxxx);
      end
   end

   // Each byte the controller reads is matched against the oldest note.
   always @(u_host.rd_ev) begin
      check({16'h0, u_host.rd_byte}, {16'h0, rq.pop_front()});
   end

   // =====================================================================
   // Helper tasks
   // =====================================================================
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic ack;
      u_host.send_byte(b, ack);
      check({23'h0, ack}, {23'h0, exp_ack});
   endtask : put

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      logic [15:0] idx;
      logic [7:0] dat [4];
      logic [7:0] bad;
      sys_rst = 1'b1;
      iface_rst = 1'b0;
      void'($urandom(32'haa78e4cc));
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // Interface reset while the target holds its acknowledge low.
      u_host.start_cond();
      put(ITG_ADDR_WR, 1'b0);
      for (int i = 0; i < 8; i++) begin
         u_host.send_bit(1'b1);
      end
      #700;
      check({23'h0, sda_oe}, 24'h1);
      check({23'h0, sda_out}, 24'h0);
      @(posedge clk_sys);
      iface_rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      iface_rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check({23'h0, sda_oe}, 24'h0);
      // The 0xff byte already landed as the pointer's high half before the reset.
      check({8'h0, reg_ptr}, {8'h0, 8'hff, ITG_PTR_RST[7:0]});
      u_host.stop_cond();
      done("interface reset");
      // A foreign address, then bytes sent with no start at all.
      bad = 8'($urandom);
      if (bad[7:1] == ITG_ADDR_WR[7:1]) begin
         bad = 8'ha0;
      end
      u_host.start_cond();
      put(bad, 1'b1);
      // The controller gives up on a refused byte and closes the message.
      u_host.stop_cond();
      u_host.scl_low <= 1'b1;
      #300;
      put(ITG_ADDR_WR, 1'b1);
      put(ITG_ADDR_WR, 1'b1);
      put(8'h00, 1'b1);
      u_host.stop_cond();
      done("refused traffic");
      // Burst write, pointer reload, burst read; second pass with spikes.
      for (int g = 0; g < 2; g++) begin
         idx = 16'($urandom);
         u_host.glitch = g[0];
         u_host.start_cond();
         put(ITG_ADDR_WR, 1'b0);
         put(idx[15:8], 1'b0);
         put(idx[7:0], 1'b0);
         for (int i = 0; i < 4; i++) begin
            dat[i] = 8'($urandom);
            wq.push_back({idx + 16'(i), dat[i]});
            put(dat[i], 1'b0);
         end
         u_host.stop_cond();
         check({8'h0, reg_ptr}, {8'h0, idx + 16'h0004});
         u_host.start_cond();
         put(ITG_ADDR_WR, 1'b0);
         put(idx[15:8], 1'b0);
         put(idx[7:0], 1'b0);
         if (g == 0) begin
            u_host.stop_cond();
            check({8'h0, reg_ptr}, {8'h0, idx});
         end
         u_host.start_cond();
         put(ITG_ADDR_RD, 1'b0);
         for (int i = 0; i < 4; i++) begin
            rq.push_back(dat[i]);
            u_host.recv_byte(i == 3);
         end
         u_host.stop_cond();
         check({8'h0, reg_ptr}, {8'h0, idx + 16'h0004});
         check({23'h0, sda_line}, 24'h1);
         done("burst write and read");
      end
      report_and_stop();
   end
endmodule : testbench
